// file: include/ccd_consts.svh
// Purpose: constants of the 8-bit core subset: reset values, flag positions, opcodes, cycle counts, bus offsets
// Assumes: included by its bare name from the core
// Notes: definitions only
`ifndef CCD_CONSTS_SVH
`define CCD_CONSTS_SVH

// condition-code bit positions
`define CCD_CCR_V          7
`define CCD_CCR_H          4
`define CCD_CCR_I          3
`define CCD_CCR_N          2
`define CCD_CCR_Z          1
`define CCD_CCR_C          0

// reset values
`define CCD_CCR_RESET      8'h60
`define CCD_PC_RESET       16'h0000
`define CCD_SP_RESET       16'h00ff
`define CCD_HX_RESET       16'h0000
`define CCD_ACC_RESET      8'h00
`define CCD_RUN_RESET      1'b0

// opcodes outside the regular groups
`define CCD_OP_PREFIX      8'h9e
`define CCD_OP_AIS         8'ha7
`define CCD_OP_AIX         8'haf
`define CCD_OP_MUL         8'h42
`define CCD_OP_DIV         8'h52
`define CCD_OP_BR_NC       8'h24
`define CCD_OP_BR_C        8'h25
`define CCD_OP_BR_Z        8'h27
`define CCD_OP_BR_HI       8'h22
`define CCD_OP_BR_NH       8'h28
`define CCD_OP_BR_H        8'h29
`define CCD_OP_BR_GE       8'h90
`define CCD_OP_BR_GT       8'h92

// cycle counts per instruction form
`define CCD_CYC_IMM        4'h2
`define CCD_CYC_DIR        4'h3
`define CCD_CYC_EXT        4'h4
`define CCD_CYC_IX2        4'h4
`define CCD_CYC_IX1        4'h3
`define CCD_CYC_IX         4'h2
`define CCD_CYC_SP1        4'h4
`define CCD_CYC_SP2        4'h5
`define CCD_CYC_SH_DIR     4'h4
`define CCD_CYC_SH_INH     4'h1
`define CCD_CYC_SH_IX1     4'h4
`define CCD_CYC_SH_IX      4'h3
`define CCD_CYC_SH_SP1     4'h5
`define CCD_CYC_BIT_CLEAR_DIRECT       4'h4
`define CCD_CYC_BRANCH     4'h3
`define CCD_CYC_ADJ        4'h2
`define CCD_CYC_MUL        4'h5
`define CCD_CYC_DIV        4'h7
`define CCD_CYC_NOP        4'h1

// bus register offsets (low 12 address bits)
`define CCD_OFS_CTRL       12'h000
`define CCD_OFS_CORE       12'h004
`define CCD_OFS_INDEX      12'h008
`define CCD_OFS_PTRS       12'h00c
`define CCD_CTRL_RUN       0

`endif

// file: include/ccd_pkg.sv
// Purpose: types of the 8-bit core subset
// Assumes: nothing
// Notes: state codes are one-hot
package ccd_pkg;

    typedef enum logic [4:0] {
        ST_FETCH = 5'h01,
        ST_OPER  = 5'h02,
        ST_READ  = 5'h04,
        ST_WRITE = 5'h08,
        ST_PAD   = 5'h10
    } ccd_state_type;

    typedef enum logic [3:0] {
        MD_INH, MD_IMM, MD_DIR, MD_EXT, MD_IX2, MD_IX1, MD_IX, MD_SP1, MD_SP2, MD_REL
    } ccd_mode_type;

    typedef enum logic [3:0] {
        OP_NONE, OP_ADC, OP_ADD, OP_AND, OP_ASL, OP_ASR, OP_BIT_CLEAR_DIRECT, OP_AIS, OP_AIX, OP_BR, OP_MUL, OP_DIV
    } ccd_op_type;

    typedef struct packed {
        ccd_mode_type mode;
        logic [1:0]   nb;
        logic         rmw;
        ccd_op_type   op;
        logic [3:0]   cyc;
    } ccd_dec_type;

    typedef struct packed {
        ccd_state_type st;
        logic [15:0]   pc;
        logic [15:0]   hx;
        logic [15:0]   sp;
        logic [15:0]   ea;
        logic [7:0]    opnd;
        logic [7:0]    acc;
        logic [7:0]    cond_code_reg;
        logic [7:0]    opc;
        logic          pre;
        logic [1:0]    left;
        logic [3:0]    cnt;
        logic [15:0]   addr;
        logic          re;
        logic          we;
        logic [7:0]    wdata;
        logic          run;
        logic          wrPend;
        logic [11:0]   wrAddr;
        logic [31:0]   rdata;
        logic          ready;
        logic          resp;
    } ccd_core_type;

endpackage : ccd_pkg

// file: logic/ccd_core.sv
// Purpose: 8-bit core executing the add, and, shift, stack/index adjust, bit clear and branch subset
// Assumes: memory answers a read combinationally in the cycle its address stands; writes take at the clock edge
// Notes: AHB-Lite slave gives run control, pc load while halted and a view of the programmer registers
//
// Overview of operation
// [RULE1] one 8-bit accumulator supplies operands and receives arithmetic and logic results
// [RULE2] 16-bit index pair with separately usable high and low bytes
// [RULE3] indexed modes form the effective address from the index pair
// [RULE4] 16-bit stack pointer adjusted by dedicated instructions
// [RULE5] 16-bit addresses cover one 64 KB program and data space
// [RULE6] unsigned 8x8 multiply and 16/8 divide run as single instructions
// [RULE7] add with carry updates V H N Z C, keeps I, with table cycle counts
// [RULE8] add without carry, same flags and cycle counts as add with carry
// [RULE9] opcode A7 adds sign-extended immediate to stack pointer, 2 cycles, flags kept
// [RULE10] opcode AF adds sign-extended immediate to index pair, 2 cycles, flags kept
// [RULE11] logical and clears V, updates N Z, keeps H I C
// [RULE12] arithmetic left shift equals logical left shift, updates V N Z C
// [RULE13] arithmetic right shift updates V N Z C in six forms
// [RULE14] odd opcodes 11 to 1F clear bit n of a direct byte in 4 cycles
// [RULE15] branches on carry clear, carry set, zero set, carry and zero clear; 3 cycles
// [RULE16] opcodes 28 and 29 branch on half carry clear or set
// [RULE17] opcode 90 branches when N xor V is zero
// [RULE18] opcode 92 branches when Z or (N xor V) is zero
// [RULE19] prefix 9E selects stack-relative forms, offset added to stack pointer
// [RULE20] shifts move the lost bit to carry; V becomes N xor C
`timescale 1ns/1ps
`include "ccd_consts.svh"

module ccd_core
    import ccd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    output logic [15:0]      memAddr,
    output logic             memRead,
    output logic             memWrite,
    output logic [7:0]       memWdata,
    input  wire logic [7:0]  memRdata,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp
);

    localparam ccd_core_type RESET_VAL = '{
        st: ST_FETCH, pc: `CCD_PC_RESET, hx: `CCD_HX_RESET, sp: `CCD_SP_RESET,
        acc: `CCD_ACC_RESET, cond_code_reg: `CCD_CCR_RESET, addr: `CCD_PC_RESET, run: `CCD_RUN_RESET,
        ready: 1'b1, default: '0};

    ccd_core_type r_reg;
    ccd_core_type r_next;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // decode: addressing form, operand bytes, operation and cycle budget

    function automatic ccd_dec_type decodeOp(input logic pre, input logic [7:0] op);
        ccd_dec_type dc;
        logic [3:0]  hi;
        logic [3:0]  lo;
        dc = '{mode: MD_INH, nb: 2'h0, rmw: 1'b0, op: OP_NONE, cyc: `CCD_CYC_NOP};
        hi = op[7:4];
        lo = op[3:0];
        if (!pre && op == `CCD_OP_AIS) begin
            dc = '{mode: MD_IMM, nb: 2'h1, rmw: 1'b0, op: OP_AIS, cyc: `CCD_CYC_ADJ}; // RULE9
        end else if (!pre && op == `CCD_OP_AIX) begin
            dc = '{mode: MD_IMM, nb: 2'h1, rmw: 1'b0, op: OP_AIX, cyc: `CCD_CYC_ADJ}; // RULE10
        end else if ((lo == 4'h9 || lo == 4'hb || lo == 4'h4) && hi >= 4'ha) begin
            dc.op = (lo == 4'h9) ? OP_ADC : (lo == 4'hb) ? OP_ADD : OP_AND; // RULE7 RULE8 RULE11
            case (hi)
                4'ha: dc = '{mode: MD_IMM, nb: 2'h1, rmw: 1'b0, op: dc.op, cyc: `CCD_CYC_IMM};
                4'hb: dc = '{mode: MD_DIR, nb: 2'h1, rmw: 1'b0, op: dc.op, cyc: `CCD_CYC_DIR};
                4'hc: dc = '{mode: MD_EXT, nb: 2'h2, rmw: 1'b0, op: dc.op, cyc: `CCD_CYC_EXT};
                4'hd: dc = pre ? '{mode: MD_SP2, nb: 2'h2, rmw: 1'b0, op: dc.op, cyc: `CCD_CYC_SP2}
                               : '{mode: MD_IX2, nb: 2'h2, rmw: 1'b0, op: dc.op, cyc: `CCD_CYC_IX2};
                4'he: dc = pre ? '{mode: MD_SP1, nb: 2'h1, rmw: 1'b0, op: dc.op, cyc: `CCD_CYC_SP1}
                               : '{mode: MD_IX1, nb: 2'h1, rmw: 1'b0, op: dc.op, cyc: `CCD_CYC_IX1};
                4'hf: dc = '{mode: MD_IX, nb: 2'h0, rmw: 1'b0, op: dc.op, cyc: `CCD_CYC_IX};
                default: dc.op = OP_NONE;
            endcase
            if (pre && hi != 4'hd && hi != 4'he) begin
                dc = '{mode: MD_INH, nb: 2'h0, rmw: 1'b0, op: OP_NONE, cyc: `CCD_CYC_NOP};
            end
        end else if ((lo == 4'h7 || lo == 4'h8) && hi >= 4'h3 && hi <= 4'h7 && (!pre || hi == 4'h6)) begin
            dc.op = (lo == 4'h8) ? OP_ASL : OP_ASR; // RULE12 RULE13
            case (hi)
                4'h3: dc = '{mode: MD_DIR, nb: 2'h1, rmw: 1'b1, op: dc.op, cyc: `CCD_CYC_SH_DIR};
                4'h4,
                4'h5: dc = '{mode: MD_INH, nb: 2'h0, rmw: 1'b0, op: dc.op, cyc: `CCD_CYC_SH_INH};
                4'h6: dc = pre ? '{mode: MD_SP1, nb: 2'h1, rmw: 1'b1, op: dc.op, cyc: `CCD_CYC_SH_SP1}
                               : '{mode: MD_IX1, nb: 2'h1, rmw: 1'b1, op: dc.op, cyc: `CCD_CYC_SH_IX1};
                4'h7: dc = '{mode: MD_IX, nb: 2'h0, rmw: 1'b1, op: dc.op, cyc: `CCD_CYC_SH_IX};
                default: dc.op = OP_NONE;
            endcase
        end else if (!pre && hi == 4'h1 && op[0]) begin
            dc = '{mode: MD_DIR, nb: 2'h1, rmw: 1'b1, op: OP_BIT_CLEAR_DIRECT, cyc: `CCD_CYC_BIT_CLEAR_DIRECT}; // RULE14
        end else if (!pre && (op == `CCD_OP_BR_NC || op == `CCD_OP_BR_C || op == `CCD_OP_BR_Z ||
                              op == `CCD_OP_BR_HI || op == `CCD_OP_BR_NH || op == `CCD_OP_BR_H ||
                              op == `CCD_OP_BR_GE || op == `CCD_OP_BR_GT)) begin
            dc = '{mode: MD_REL, nb: 2'h1, rmw: 1'b0, op: OP_BR, cyc: `CCD_CYC_BRANCH}; // RULE15
        end else if (!pre && op == `CCD_OP_MUL) begin
            dc = '{mode: MD_INH, nb: 2'h0, rmw: 1'b0, op: OP_MUL, cyc: `CCD_CYC_MUL}; // RULE6
        end else if (!pre && op == `CCD_OP_DIV) begin
            dc = '{mode: MD_INH, nb: 2'h0, rmw: 1'b0, op: OP_DIV, cyc: `CCD_CYC_DIV}; // RULE6
        end
        return dc;
    endfunction : decodeOp

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // byte alu: returns {new flags, result}

    function automatic logic [15:0] aluByte(input ccd_op_type op, input logic [7:0] a, input logic [7:0] m,
                                            input logic [7:0] cond_code_reg, input logic [2:0] bitn);
        logic [8:0] sum;
        logic [7:0] res;
        logic [7:0] f;
        sum = 9'h000;
        res = a;
        f   = cond_code_reg;
        case (op)
            OP_ADC,
            OP_ADD: begin
                sum = {1'b0, a} + {1'b0, m} + {8'h00, (op == OP_ADC) & cond_code_reg[`CCD_CCR_C]}; // RULE7 RULE8
                res = sum[7:0];
                f[`CCD_CCR_V] = (a[7] & m[7] & ~res[7]) | (~a[7] & ~m[7] & res[7]);
                f[`CCD_CCR_H] = (a[3] & m[3]) | (m[3] & ~res[3]) | (~res[3] & a[3]);
                f[`CCD_CCR_C] = sum[8];
            end
            OP_AND: begin
                res = a & m; // RULE11
                f[`CCD_CCR_V] = 1'b0;
            end
            OP_ASL: begin
                res = {m[6:0], 1'b0}; // RULE12 RULE20
                f[`CCD_CCR_C] = m[7];
                f[`CCD_CCR_V] = res[7] ^ m[7];
            end
            OP_ASR: begin
                res = {m[7], m[7:1]}; // RULE13 RULE20
                f[`CCD_CCR_C] = m[0];
                f[`CCD_CCR_V] = m[7] ^ m[0];
            end
            OP_BIT_CLEAR_DIRECT: res = m & ~(8'h01 << bitn); // RULE14
            default: res = a;
        endcase
        if (op == OP_ADC || op == OP_ADD || op == OP_AND || op == OP_ASL || op == OP_ASR) begin
            f[`CCD_CCR_N] = res[7];
            f[`CCD_CCR_Z] = (res == 8'h00);
        end
        return {f, res};
    endfunction : aluByte

    function automatic logic takeBranch(input logic [7:0] op, input logic [7:0] cond_code_reg);
        logic nv;
        nv = cond_code_reg[`CCD_CCR_N] ^ cond_code_reg[`CCD_CCR_V];
        case (op)
            `CCD_OP_BR_NC: takeBranch = ~cond_code_reg[`CCD_CCR_C]; // RULE15
            `CCD_OP_BR_C:  takeBranch = cond_code_reg[`CCD_CCR_C];
            `CCD_OP_BR_Z:  takeBranch = cond_code_reg[`CCD_CCR_Z];
            `CCD_OP_BR_HI: takeBranch = ~(cond_code_reg[`CCD_CCR_C] | cond_code_reg[`CCD_CCR_Z]);
            `CCD_OP_BR_NH: takeBranch = ~cond_code_reg[`CCD_CCR_H]; // RULE16
            `CCD_OP_BR_H:  takeBranch = cond_code_reg[`CCD_CCR_H];
            `CCD_OP_BR_GE: takeBranch = ~nv; // RULE17
            `CCD_OP_BR_GT: takeBranch = ~(cond_code_reg[`CCD_CCR_Z] | nv); // RULE18
            default:       takeBranch = 1'b0;
        endcase
    endfunction : takeBranch

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        ccd_dec_type dc;
        logic [15:0] aluOut;
        logic [15:0] word;
        logic [15:0] eaNew;
        logic [15:0] quot;
        logic        done;
        dc     = decodeOp(r_reg.pre, r_reg.opc);
        aluOut = 16'h0000;
        word   = {r_reg.opnd, memRdata};
        eaNew  = 16'h0000;
        quot   = 16'h0000;
        done   = 1'b0;
        r_next = r_reg;
        r_next.re  = 1'b0;
        r_next.we  = 1'b0;
        r_next.cnt = r_reg.cnt + 4'h1;
        case (r_reg.st)
            ST_FETCH: begin
                if (r_reg.run || r_reg.pre) begin
                    r_next.pc = r_reg.pc + 16'h0001;
                    if (!r_reg.pre && memRdata == `CCD_OP_PREFIX) begin
                        r_next.pre  = 1'b1; // RULE19
                        r_next.addr = r_reg.pc + 16'h0001;
                        r_next.re   = 1'b1;
                    end else begin
                        dc = decodeOp(r_reg.pre, memRdata);
                        r_next.opc = memRdata;
                        if (dc.nb != 2'h0) begin
                            r_next.st   = ST_OPER;
                            r_next.left = dc.nb;
                            r_next.addr = r_reg.pc + 16'h0001;
                            r_next.re   = 1'b1;
                        end else if (dc.mode == MD_IX) begin
                            r_next.ea   = r_reg.hx; // RULE3
                            r_next.addr = r_reg.hx;
                            r_next.st   = ST_READ;
                            r_next.re   = 1'b1;
                        end else begin
                            if (dc.op == OP_ASL || dc.op == OP_ASR) begin
                                aluOut = aluByte(dc.op, 8'h00, memRdata[4] ? r_reg.hx[7:0] : r_reg.acc,
                                                 r_reg.cond_code_reg, 3'h0);
                                r_next.cond_code_reg = aluOut[15:8];
                                if (memRdata[4]) begin
                                    r_next.hx[7:0] = aluOut[7:0]; // RULE2
                                end else begin
                                    r_next.acc = aluOut[7:0]; // RULE1
                                end
                            end else if (dc.op == OP_MUL) begin
                                r_next.hx[7:0] = 8'(({8'h00, r_reg.hx[7:0]} * {8'h00, r_reg.acc}) >> 8); // RULE6
                                r_next.acc     = 8'({8'h00, r_reg.hx[7:0]} * {8'h00, r_reg.acc});
                                r_next.cond_code_reg[`CCD_CCR_H] = 1'b0;
                                r_next.cond_code_reg[`CCD_CCR_C] = 1'b0;
                            end else if (dc.op == OP_DIV) begin
                                if (r_reg.hx[7:0] == 8'h00) begin
                                    r_next.cond_code_reg[`CCD_CCR_C] = 1'b1;
                                end else begin
                                    quot = {r_reg.hx[15:8], r_reg.acc} / {8'h00, r_reg.hx[7:0]}; // RULE6
                                    if (quot[15:8] != 8'h00) begin
                                        r_next.cond_code_reg[`CCD_CCR_C] = 1'b1;
                                    end else begin
                                        r_next.acc      = quot[7:0];
                                        r_next.hx[15:8] = 8'({r_reg.hx[15:8], r_reg.acc} % {8'h00, r_reg.hx[7:0]});
                                        r_next.cond_code_reg[`CCD_CCR_C] = 1'b0;
                                        r_next.cond_code_reg[`CCD_CCR_Z] = (quot[7:0] == 8'h00);
                                    end
                                end
                            end
                            done = 1'b1;
                        end
                    end
                end else begin
                    r_next.cnt = 4'h0;
                end
            end
            ST_OPER: begin
                r_next.opnd = memRdata;
                r_next.left = r_reg.left - 2'h1;
                r_next.pc   = r_reg.pc + 16'h0001;
                if (r_reg.left == 2'h1) begin
                    case (dc.mode)
                        MD_DIR:  eaNew = {8'h00, memRdata};
                        MD_EXT:  eaNew = word; // RULE5
                        MD_IX2:  eaNew = r_reg.hx + word; // RULE3
                        MD_IX1:  eaNew = r_reg.hx + {8'h00, memRdata};
                        MD_SP1:  eaNew = r_reg.sp + {8'h00, memRdata}; // RULE19
                        MD_SP2:  eaNew = r_reg.sp + word;
                        default: eaNew = 16'h0000;
                    endcase
                    if (dc.mode == MD_IMM) begin
                        if (dc.op == OP_AIS) begin
                            r_next.sp = r_reg.sp + {{8{memRdata[7]}}, memRdata}; // RULE4 RULE9
                        end else if (dc.op == OP_AIX) begin
                            r_next.hx = r_reg.hx + {{8{memRdata[7]}}, memRdata}; // RULE10
                        end else begin
                            aluOut     = aluByte(dc.op, r_reg.acc, memRdata, r_reg.cond_code_reg, 3'h0);
                            r_next.acc = aluOut[7:0];
                            r_next.cond_code_reg = aluOut[15:8];
                        end
                        done = 1'b1;
                    end else if (dc.mode == MD_REL) begin
                        if (takeBranch(r_reg.opc, r_reg.cond_code_reg)) begin
                            r_next.pc = r_reg.pc + 16'h0001 + {{8{memRdata[7]}}, memRdata}; // RULE15
                        end
                        done = 1'b1;
                    end else begin
                        r_next.ea   = eaNew;
                        r_next.addr = eaNew;
                        r_next.st   = ST_READ;
                        r_next.re   = 1'b1;
                    end
                end else begin
                    r_next.addr = r_reg.pc + 16'h0001;
                    r_next.re   = 1'b1;
                end
            end
            ST_READ: begin
                aluOut = aluByte(dc.op, r_reg.acc, memRdata, r_reg.cond_code_reg, r_reg.opc[3:1]);
                r_next.cond_code_reg = aluOut[15:8];
                if (dc.rmw) begin
                    r_next.we    = 1'b1;
                    r_next.wdata = aluOut[7:0];
                    r_next.addr  = r_reg.ea;
                    r_next.st    = ST_WRITE;
                end else begin
                    r_next.acc = aluOut[7:0]; // RULE1
                    done       = 1'b1;
                end
            end
            ST_WRITE: done = 1'b1;
            ST_PAD:   done = 1'b1;
            default:  r_next.st = ST_FETCH;
        endcase
        // hold in the pad state until the instruction has used its full cycle budget
        if (done) begin
            if (r_next.cnt >= dc.cyc) begin
                r_next.st   = ST_FETCH;
                r_next.cnt  = 4'h0;
                r_next.pre  = 1'b0;
                r_next.addr = r_next.pc;
                r_next.re   = r_next.run;
            end else begin
                r_next.st = ST_PAD;
            end
        end
        // bus slave: data phase of a write
        if (r_reg.wrPend) begin
            case (r_reg.wrAddr)
                `CCD_OFS_CTRL: r_next.run = hwdata[`CCD_CTRL_RUN];
                `CCD_OFS_PTRS: begin
                    if (!r_reg.run && r_reg.st == ST_FETCH && !r_reg.pre) begin
                        r_next.pc   = hwdata[15:0];
                        r_next.addr = hwdata[15:0];
                    end
                end
                default: r_next.wrAddr = r_reg.wrAddr;
            endcase
        end
        // bus slave: address phase, read data is ready for the data phase
        r_next.wrPend = 1'b0;
        r_next.ready  = 1'b1;
        r_next.resp   = 1'b0;
        if (hsel && htrans[1] && hready) begin
            r_next.wrPend = hwrite;
            r_next.wrAddr = haddr[11:0];
            if (!hwrite) begin
                case (haddr[11:0])
                    `CCD_OFS_CTRL:  r_next.rdata = {31'h0000_0000, r_reg.run};
                    `CCD_OFS_CORE:  r_next.rdata = {11'h000, r_reg.st, r_reg.cond_code_reg, r_reg.acc};
                    `CCD_OFS_INDEX: r_next.rdata = {r_reg.sp, r_reg.hx};
                    `CCD_OFS_PTRS:  r_next.rdata = {16'h0000, r_reg.pc};
                    default:        r_next.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r_reg <= RESET_VAL;
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign memAddr   = r_reg.addr;
    assign memRead   = r_reg.re;
    assign memWrite  = r_reg.we;
    assign memWdata  = r_reg.wdata;
    assign hreadyout = r_reg.ready;
    assign hrdata    = r_reg.rdata;
    assign hresp     = r_reg.resp;

endmodule : ccd_core

// file: tb/ccd_core_chk.sv
// Purpose: core port assertions; Assumes: one bus slave
// Notes: bound to each core
`timescale 1ns/1ps
module ccd_core_chk (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [15:0] memAddr,
    input wire logic        memRead,
    input wire logic        memWrite,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp);
    wire rdTk = hsel && htrans[1] && hreadyout && !hwrite;
    wire ctlWr = hsel && htrans[1] && hreadyout && hwrite && haddr[11:0] == 12'h0;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_ok; hreadyout && !hresp; endproperty
    a_ok: assert property (p_ok) else $error("not okay");
    property p_gap; rdTk && haddr[11:4] != 8'h0 |=> hrdata == 32'h0; endproperty
    a_gap: assert property (p_gap) else $error("gap read");
    property p_hold; $stable(hrdata) || $past(rdTk); endproperty
    a_hold: assert property (p_hold) else $error("data moved");
    property p_excl; !(memRead && memWrite); endproperty
    a_excl: assert property (p_excl) else $error("read with write");
    property p_wr1; memWrite |=> !memWrite; endproperty
    a_wr1: assert property (p_wr1) else $error("long write");
    property p_rmw; memWrite |-> $past(memRead) && $stable(memAddr); endproperty
    a_rmw: assert property (p_rmw) else $error("bad write back");
    property p_halt; ctlWr ##1 !hwdata[0] |-> ##[1:9] !memRead [*8]; endproperty
    a_halt: assert property (p_halt) else $error("no halt");
    property p_run; ctlWr ##1 hwdata[0] |-> ##[1:4] memRead; endproperty
    a_run: assert property (p_run) else $error("no start");
    c_wr: cover property (memWrite);
    c_gap: cover property (rdTk && haddr[11:4] != 8'h0);
    c_halt: cover property (ctlWr ##1 !hwdata[0]);
endmodule : ccd_core_chk
bind ccd_core ccd_core_chk ccd_core_chk_inst (.clk, .nrst, .memAddr, .memRead, .memWrite, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hreadyout, .hrdata, .hresp);

// file: tb/ccd_mem_model.sv
// Purpose: 64 KB program and data memory; Assumes: combinational read
// Notes: write lands at the clock edge, bench preloads contents
`timescale 1ns/1ps
module ccd_mem_model (
    input wire logic        clk,
    input wire logic [15:0] addr,
    input wire logic        we,
    input wire logic [7:0]  wdata,
    output logic [7:0]      rdata);
    logic [7:0] memArray [0:65535];
    assign rdata = memArray[addr];
    always @(posedge clk) if (we) memArray[addr] <= wdata;
endmodule : ccd_mem_model

// file: tb/cpu_core_decode_subset_tb.sv
// Purpose: runs two short programs, checks registers; Assumes: program preloaded
// Notes: program ends in a branch to itself
`timescale 1ns/1ps
module cpu_core_decode_subset_tb;
    logic         clk = 1'b0, nrst = 1'b0, hwrite = 1'b0, memRead, memWrite, hreadyout, hresp;
    logic [7:0]   memWdata, memRdata;
    logic [15:0]  memAddr;
    logic [31:0]  haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]   htrans = 2'h0;
    logic [135:0] prog = 136'ha905_abfb_a7fe_af81_2502_ab07_4811_2024_fe;
    logic [95:0]  progB = 96'hab83_479e_e4fe_9002_ab01_92fe;
    int           errTotal, checked;
    always #20 clk = ~clk;
    ccd_core ccd_core_inst (.clk, .nrst, .memAddr, .memRead, .memWrite, .memWdata, .memRdata, .hsel(1'b1), .haddr,
        .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp);
    ccd_mem_model ccd_mem_model_inst (.clk, .addr(memAddr), .we(memWrite), .wdata(memWdata), .rdata(memRdata));
    ////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        errTotal += int'(seen !== exp);
        if (seen !== exp) $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    endtask : check
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        {htrans, hwrite, haddr} <= {2'h2, w, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        {htrans, hwdata} <= {2'h0, d};
        do @(posedge clk); while (hreadyout !== 1'b1);
        if (!w) check(hrdata, d);
    endtask : xfer
    task automatic tallyAndFinish;
        if (errTotal == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tallyAndFinish
    initial begin
        repeat (3000) @(posedge clk);
        errTotal++;
        tallyAndFinish;
    end
    initial begin
        for (int i = 0; i < 17; i++) ccd_mem_model_inst.memArray[i] = prog[135 - 8 * i -: 8];
        ccd_mem_model_inst.memArray[16'h20] = 8'hff;
        for (int i = 0; i < 12; i++) ccd_mem_model_inst.memArray[16'h40 + i] = progB[95 - 8 * i -: 8];
        ccd_mem_model_inst.memArray[16'h1fb] = 8'h4f;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        xfer(1'b0, 32'h4, 32'h1_6000);
        xfer(1'b0, 32'hff0, 32'h0);
        xfer(1'b1, 32'h0, 32'h1);
        repeat (40) @(posedge clk);
        xfer(1'b1, 32'h0, 32'h0);
        xfer(1'b0, 32'h8, 32'hfd_ff81);
        xfer(1'b0, 32'h4, 32'h1_7200);
        xfer(1'b0, 32'hc, 32'hf);
        check({24'h0, ccd_mem_model_inst.memArray[16'h20]}, 32'hfe);
        // second program at 0x40: add, shift right, stack-relative and, signed branches
        xfer(1'b1, 32'hc, 32'h40);
        xfer(1'b1, 32'h0, 32'h1);
        repeat (40) @(posedge clk);
        xfer(1'b1, 32'h0, 32'h0);
        xfer(1'b0, 32'h4, 32'h1_6141);
        xfer(1'b0, 32'hc, 32'h4a);
        tallyAndFinish;
    end
endmodule : cpu_core_decode_subset_tb
